// ==== rsl_pkg.sv ====
// Shared constants and types for the reset strap latch block
package rsl_pkg;

	// ****************************************************************
	// Register indexes on the management port
	// ****************************************************************
	localparam logic [4:0] RSL_REG_CTRL = 5'h00;
	localparam logic [4:0] RSL_REG_ADV = 5'h04;
	localparam logic [4:0] RSL_REG_MISC = 5'h16;
	localparam logic [4:0] RSL_REG_STRAP = 5'h1B;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int RSL_CTRL_SPEED = 13;
	localparam int RSL_CTRL_ANEG = 12;
	localparam int RSL_CTRL_ISO = 10;
	localparam int RSL_CTRL_DUPLEX = 8;
	localparam int RSL_ADV_100FD = 8;
	localparam int RSL_ADV_100HD = 7;
	localparam int RSL_ADV_10FD = 6;
	localparam int RSL_ADV_10HD = 5;
	localparam int RSL_MISC_BCOFF = 9;

	// ****************************************************************
	// Codes and reset values
	// ****************************************************************
	localparam logic [2:0] RSL_MODE_MII = 3'h0;
	localparam logic [2:0] RSL_MODE_B2B = 3'h6;
	localparam logic [1:0] RSL_ADDR_HI = 2'h0;
	localparam logic [4:0] RSL_ADV_SELECTOR = 5'h01;
	localparam logic [15:0] RSL_RD_ZERO = 16'h0000;
	// Pull defaults in strap order, nand_tree_n down to mgmt_addr
	localparam logic [11:0] RSL_STRAP_DFLT = 12'hB81;

	// Strap pins, one bit per pin, as they sit on the pads
	typedef struct packed {
		logic nand_tree_n_strap;
		logic bcast_disable_strap;
		logic autoneg_en_strap;
		logic duplex_half_strap;
		logic speed_100_strap;
		logic isolate_strap;
		logic [2:0] iface_mode_strap;
		logic [2:0] mgmt_addr_strap;
	} rsl_straps_t;

	// Configuration handed to the mode logic
	typedef struct packed {
		logic [4:0] mgmt_addr;
		logic addr0_bcast;
		logic [2:0] iface_mode;
		logic mode_b2b;
		logic mode_reserved;
		logic nand_tree_en;
		logic isolate;
		logic speed_100;
		logic full_duplex;
		logic autoneg_en;
	} rsl_cfg_t;

endpackage

// ==== rsl_strap_pad.sv ====
// Strap pad group: input while in reset, capture, then normal output
`timescale 1ns/10ps
module rsl_strap_pad #(
	parameter int W = 12,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_capture,
	input wire logic i_drive,
	// Pads
	input wire logic [W-1:0] i_pin,
	input wire logic [W-1:0] i_func,
	output logic [W-1:0] o_captured,
	output logic [W-1:0] o_pin_out,
	output logic [W-1:0] o_pin_oe_n
);

	logic [W-1:0] cap_r;
	logic [W-1:0] out_r;

	// Capture once on release; reset shows the pull defaults
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cap_r <= RST_VAL;
		end else if (i_capture) begin
			cap_r <= i_pin;
		end
	end

	// Output data held low until the pads turn around
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			out_r <= '0;
		end else begin
			out_r <= i_drive ? i_func : '0;
		end
	end

	// Pads float while the board pulls set the level
	assign o_pin_oe_n = {W{~i_drive}};
	assign o_pin_out = out_r;
	assign o_captured = cap_r;

endmodule

// ==== rsl_reset_strap_latch.sv ====
// Reset strap latch: pad capture, strap-loaded registers, config out
//
// Overview of operation
// - Sample all straps once at reset release
// - Pads are pulled inputs in reset, outputs after
// - Address low bits from straps, default one
// - Address upper two bits are always zero
// - Address zero broadcast unless strap or software
// - Mode 000 normal, 110 back-to-back, rest reserved
// - Isolate strap loads control bit ten
// - Speed strap sets speed and advertised abilities
// - Speed strap loads control bit thirteen
// - Duplex strap loads control bit eight, inverted
// - Autoneg strap loads control bit twelve
// - Broadcast-disable strap held internally
// - Active-low NAND-tree strap enables test mode
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
module rsl_reset_strap_latch
	import rsl_pkg::*;
#(
	parameter int AW = 5,
	parameter int DW = 16
) (
	// Clock and chip reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Strap pads
	input wire rsl_straps_t i_strap_in,
	input wire rsl_straps_t i_strap_func,
	output rsl_straps_t o_strap_out,
	output rsl_straps_t o_strap_oe_n,
	// Register port
	input wire logic [AW-1:0] i_addr,
	input wire logic [DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DW-1:0] o_rdata,
	// Configuration to the mode logic
	output rsl_cfg_t o_cfg,
	output logic o_cfg_valid
);

	// ****************************************************************
	// Register index decode
	// ****************************************************************
	// One compare shared by the write strobes and the read mux, so the
	// two sides can never disagree on which index a register owns
	function automatic logic reg_hit(input logic [AW-1:0] a,
		input logic [4:0] idx);
		return a == AW'(idx);
	endfunction

	// ****************************************************************
	// Release detection
	// ****************************************************************
	logic rst_d_r;
	logic done_r;
	logic release_w;

	// Reset is synchronous, so the first low cycle is the release edge
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rst_d_r <= 1'b1;
			done_r <= 1'b0;
		end else begin
			rst_d_r <= 1'b0;
			done_r <= done_r | release_w;
		end
	end

	assign release_w = rst_d_r & ~i_rst;

	// ****************************************************************
	// Pads and captured straps
	// ****************************************************************
	logic [11:0] cap_w;
	rsl_straps_t cap_s;
	logic [11:0] pad_out_w;
	logic [11:0] pad_oe_n_w;

	// Pads stay inputs through the release cycle so the capture sees
	// the board pulls rather than our own drive
	rsl_strap_pad #(
		.W(12),
		.RST_VAL(RSL_STRAP_DFLT)
	) u_pad (
		.i_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_capture(release_w),
		.i_drive(done_r),
		.i_pin(i_strap_in),
		.i_func(i_strap_func),
		.o_captured(cap_w),
		.o_pin_out(pad_out_w),
		.o_pin_oe_n(pad_oe_n_w)
	);

	assign cap_s = rsl_straps_t'(cap_w);
	assign o_strap_out = rsl_straps_t'(pad_out_w);
	assign o_strap_oe_n = rsl_straps_t'(pad_oe_n_w);

	// ****************************************************************
	// Strap-loaded register bits
	// ****************************************************************
	logic spd_r;
	logic aneg_r;
	logic iso_r;
	logic fdx_r;
	logic [3:0] adv_r;
	logic bcoff_sw_r;
	logic wr_ctrl_w;
	logic wr_adv_w;
	logic wr_misc_w;

	assign wr_ctrl_w = i_wr && reg_hit(i_addr, RSL_REG_CTRL);
	assign wr_adv_w = i_wr && reg_hit(i_addr, RSL_REG_ADV);
	assign wr_misc_w = i_wr && reg_hit(i_addr, RSL_REG_MISC);

	// Control bits: reset shows the pull defaults, release loads pins,
	// otherwise only a software write moves them
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			spd_r <= 1'b1;
			aneg_r <= 1'b1;
			iso_r <= 1'b0;
			fdx_r <= 1'b0;
		end else if (release_w) begin
			spd_r <= i_strap_in.speed_100_strap;
			aneg_r <= i_strap_in.autoneg_en_strap;
			iso_r <= i_strap_in.isolate_strap;
			fdx_r <= ~i_strap_in.duplex_half_strap;
		end else if (wr_ctrl_w) begin
			spd_r <= i_wdata[RSL_CTRL_SPEED];
			aneg_r <= i_wdata[RSL_CTRL_ANEG];
			iso_r <= i_wdata[RSL_CTRL_ISO];
			fdx_r <= i_wdata[RSL_CTRL_DUPLEX];
		end
	end

	// Advertised abilities: a 10 Mbps strap withdraws both 100 bits
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			adv_r <= 4'hF;
		end else if (release_w) begin
			adv_r <= {{2{i_strap_in.speed_100_strap}}, 2'h3};
		end else if (wr_adv_w) begin
			adv_r <= i_wdata[RSL_ADV_100FD:RSL_ADV_10HD];
		end
	end

	// Software broadcast-off; straps cannot clear it, only reset or a software write of zero can
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			bcoff_sw_r <= 1'b0;
		end else if (wr_misc_w) begin
			bcoff_sw_r <= i_wdata[RSL_MISC_BCOFF];
		end
	end

	// ****************************************************************
	// Configuration outputs
	// ****************************************************************
	logic bcast_w;
	logic [2:0] mode_w;

	assign mode_w = cap_s.iface_mode_strap;
	assign bcast_w = ~(cap_s.bcast_disable_strap | bcoff_sw_r);
	assign o_cfg.mgmt_addr = {RSL_ADDR_HI, cap_s.mgmt_addr_strap};
	assign o_cfg.addr0_bcast = bcast_w;
	assign o_cfg.iface_mode = mode_w;
	assign o_cfg.mode_b2b = (mode_w == RSL_MODE_B2B);
	// Reserved codes are flagged so the mode logic can fall back
	assign o_cfg.mode_reserved = (mode_w != RSL_MODE_B2B) &&
		(mode_w != RSL_MODE_MII);
	assign o_cfg.nand_tree_en = ~cap_s.nand_tree_n_strap;
	assign o_cfg.isolate = iso_r;
	assign o_cfg.speed_100 = spd_r;
	assign o_cfg.full_duplex = fdx_r;
	assign o_cfg.autoneg_en = aneg_r;
	assign o_cfg_valid = done_r;

	// ****************************************************************
	// Register read port
	// ****************************************************************
	logic [DW-1:0] ctrl_rd_w;
	logic [DW-1:0] adv_rd_w;
	logic [DW-1:0] misc_rd_w;
	logic [DW-1:0] strap_rd_w;
	logic [DW-1:0] rd_mux_w;
	logic [DW-1:0] rdata_r;

	// Unlisted bits read zero
	assign ctrl_rd_w = {2'h0, spd_r, aneg_r, 1'b0, iso_r, 1'b0, fdx_r,
		8'h00};
	assign adv_rd_w = {7'h00, adv_r, RSL_ADV_SELECTOR};
	assign misc_rd_w = {6'h00, bcoff_sw_r, 9'h000};
	// Raw captured straps, for software to see what the board set
	assign strap_rd_w = {4'h0, cap_w};
	assign rd_mux_w =
		reg_hit(i_addr, RSL_REG_CTRL) ? ctrl_rd_w :
		reg_hit(i_addr, RSL_REG_ADV) ? adv_rd_w :
		reg_hit(i_addr, RSL_REG_MISC) ? misc_rd_w :
		reg_hit(i_addr, RSL_REG_STRAP) ? strap_rd_w : RSL_RD_ZERO;

	// Data stands for exactly one cycle after the strobe
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rdata_r <= RSL_RD_ZERO;
		end else begin
			rdata_r <= i_rd ? rd_mux_w : RSL_RD_ZERO;
		end
	end

	assign o_rdata = rdata_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	pads_in_rst_a: assert property (
		disable iff (1'b0) i_rst |=> (o_strap_oe_n == 12'hFFF))
		else $error("strap pads driven during reset");

	pads_out_after_a: assert property (
		release_w |-> (o_strap_oe_n == 12'hFFF) ##1
		(o_strap_oe_n == 12'h000))
		else $error("pads did not turn to outputs after release");

	addr_capture_a: assert property (
		release_w |=> o_cfg.mgmt_addr[2:0] ==
		$past(i_strap_in.mgmt_addr_strap))
		else $error("address straps not captured");

	addr_default_a: assert property (
		disable iff (1'b0) i_rst |=> (o_cfg.mgmt_addr == 5'h01))
		else $error("address default is not one");

	addr_upper_a: assert property (
		o_cfg.mgmt_addr[4:3] == 2'h0)
		else $error("address upper bits not zero");

	bcast_strap_a: assert property (
		release_w && i_strap_in.bcast_disable_strap |=>
		!o_cfg.addr0_bcast)
		else $error("broadcast not disabled by strap");

	bcast_sw_a: assert property (
		wr_misc_w && i_wdata[RSL_MISC_BCOFF] |=> !o_cfg.addr0_bcast)
		else $error("broadcast not disabled by software");

	mode_b2b_a: assert property (
		release_w && (i_strap_in.iface_mode_strap == 3'h6) |=>
		o_cfg.mode_b2b && !o_cfg.mode_reserved)
		else $error("back-to-back mode not selected");

	iso_capture_a: assert property (
		release_w |=> ctrl_rd_w[10] == $past(i_strap_in.isolate_strap))
		else $error("isolate strap not loaded");

	speed_adv_a: assert property (
		release_w && !i_strap_in.speed_100_strap |=>
		(adv_rd_w[8:7] == 2'h0) && (adv_rd_w[6:5] == 2'h3))
		else $error("10 Mbps strap left 100 abilities advertised");

	speed_capture_a: assert property (
		release_w |=> ctrl_rd_w[13] == $past(i_strap_in.speed_100_strap))
		else $error("speed strap not loaded");

	duplex_capture_a: assert property (
		release_w |=> ctrl_rd_w[8] ==
		!$past(i_strap_in.duplex_half_strap))
		else $error("duplex strap not loaded");

	aneg_capture_a: assert property (
		release_w |=> ctrl_rd_w[12] == $past(i_strap_in.autoneg_en_strap))
		else $error("autoneg strap not loaded");

	nand_capture_a: assert property (
		release_w |=> o_cfg.nand_tree_en ==
		!$past(i_strap_in.nand_tree_n_strap))
		else $error("NAND-tree strap not captured");

	hold_straps_a: assert property (
		!release_w && !i_wr |=> $stable(ctrl_rd_w) && $stable(cap_w) &&
		$stable(adv_rd_w))
		else $error("strap bits moved without write or release");

	read_once_a: assert property (
		!i_rd |=> (o_rdata == 16'h0000))
		else $error("read data outside its cycle");

	valid_rise_a: assert property (
		release_w |=> o_cfg_valid)
		else $error("configuration not marked valid after release");

	sample_once_a: assert property (
		o_cfg_valid |=> o_cfg_valid && $stable(cap_w))
		else $error("straps sampled again without a reset");

	pad_quiet_a: assert property (
		!o_cfg_valid |-> (o_strap_out == 12'h000))
		else $error("pad data driven before the pads turned");

	pad_follow_a: assert property (
		o_cfg_valid |=> o_strap_out == $past(i_strap_func))
		else $error("pad data does not follow normal function");

	mode_capture_a: assert property (
		release_w |=> o_cfg.iface_mode ==
		$past(i_strap_in.iface_mode_strap))
		else $error("interface mode straps not captured");

	mode_rsvd_a: assert property (
		release_w && (i_strap_in.iface_mode_strap != 3'h0) &&
		(i_strap_in.iface_mode_strap != 3'h6) |=> o_cfg.mode_reserved)
		else $error("reserved mode code not flagged");

	speed_adv100_a: assert property (
		release_w && i_strap_in.speed_100_strap |=>
		(adv_rd_w[8:5] == 4'hF))
		else $error("100 Mbps strap did not advertise all abilities");

	ctrl_dflt_a: assert property (
		disable iff (1'b0) i_rst |=> o_cfg.speed_100 &&
		o_cfg.autoneg_en && !o_cfg.isolate && !o_cfg.full_duplex)
		else $error("control bits do not show the pull defaults");

	bcast_dflt_a: assert property (
		release_w && !i_strap_in.bcast_disable_strap && !i_wr |=>
		o_cfg.addr0_bcast)
		else $error("address zero lost broadcast without a cause");

	cov_release_c: cover property (release_w ##1 o_cfg_valid);
	cov_b2b_c: cover property (release_w ##1 o_cfg.mode_b2b);
	cov_sw_ctrl_c: cover property (o_cfg_valid && wr_ctrl_w ##1 i_rd);
	cov_rst_again_c: cover property (o_cfg_valid ##1 i_rst);
	cov_rsvd_c: cover property (release_w ##1 o_cfg.mode_reserved);

endmodule

// ==== rsl_board_model.sv ====
// Board side of the strap pads: fitted resistors or internal pulls
`timescale 1ns/10ps
module rsl_board_model
	import rsl_pkg::*;
(
	// Board strap resistors
	input wire rsl_straps_t i_board,
	input wire logic i_fitted,
	// Pad drive from the device
	input wire rsl_straps_t i_pad_out,
	input wire rsl_straps_t i_pad_oe_n,
	// Resolved pad level
	output rsl_straps_t o_pin
);
	// ****************************************************************
	// Pad level resolution
	// ****************************************************************
	logic [11:0] pull_lvl;
	logic [11:0] drv;
	logic [11:0] oe_n;
	// Without fitted resistors only the internal pulls set the level
	assign pull_lvl = i_fitted ? 12'(i_board) : RSL_STRAP_DFLT;
	assign drv = 12'(i_pad_out);
	assign oe_n = 12'(i_pad_oe_n);
	// A driving pad wins over any resistor on the board
	assign o_pin = rsl_straps_t'((~oe_n & drv) | (oe_n & pull_lvl));
endmodule

// ==== tb_reset_strap_latch.sv ====
// Self-checking bench for the reset strap latch
`timescale 1ns/10ps
module tb_reset_strap_latch;
	import rsl_pkg::*;
	// ****************************************************************
	// Stimulus and observed signals
	// ****************************************************************
	logic i_ref_clk, i_rst, i_wr, i_rd, fitted;
	logic [4:0] i_addr;
	logic [15:0] i_wdata, o_rdata;
	rsl_straps_t board, pin, func, s_out, s_oe_n;
	rsl_cfg_t o_cfg;
	logic o_cfg_valid;
	int n_fail = 0;
	int samples_checked = 0;

	rsl_reset_strap_latch rsl_reset_strap_latch_i (.i_ref_clk(i_ref_clk),
		.i_rst(i_rst), .i_strap_in(pin), .i_strap_func(func),
		.o_strap_out(s_out), .o_strap_oe_n(s_oe_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_cfg(o_cfg), .o_cfg_valid(o_cfg_valid));
	rsl_board_model rsl_board_model_i (.i_board(board), .i_fitted(fitted),
		.i_pad_out(s_out), .i_pad_oe_n(s_oe_n), .o_pin(pin));

	// 20 MHz reference clock
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end

	// ****************************************************************
	// Compare tasks and expectations
	// ****************************************************************
	task chk16(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_cfg(input rsl_cfg_t got, input rsl_cfg_t exp);
		chk16(16'(got), 16'(exp));
	endtask
	// Expected configuration worked out from strap levels
	function automatic rsl_cfg_t exp_cfg(rsl_straps_t s, logic sw);
		rsl_cfg_t e;
		e.mgmt_addr = {2'h0, s.mgmt_addr_strap};
		e.addr0_bcast = ~(s.bcast_disable_strap | sw);
		e.iface_mode = s.iface_mode_strap;
		e.mode_b2b = (s.iface_mode_strap == 3'h6);
		e.mode_reserved = (s.iface_mode_strap != 3'h0) && !e.mode_b2b;
		e.nand_tree_en = ~s.nand_tree_n_strap;
		e.isolate = s.isolate_strap;
		e.speed_100 = s.speed_100_strap;
		e.full_duplex = ~s.duplex_half_strap;
		e.autoneg_en = s.autoneg_en_strap;
		return e;
	endfunction
	function automatic logic [15:0] exp_ctrl(rsl_straps_t s);
		return {2'h0, s.speed_100_strap, s.autoneg_en_strap, 1'b0,
			s.isolate_strap, 1'b0, ~s.duplex_half_strap, 8'h00};
	endfunction

	// ****************************************************************
	// Bus and reset tasks
	// ****************************************************************
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 chk16(o_rdata, exp);
	endtask
	// Reset held eleven cycles, then release with the given board straps
	task do_reset(input rsl_straps_t s, input logic fit);
		@(posedge i_ref_clk);
		board <= s;
		fitted <= fit;
		i_rst <= 1'b1;
		repeat (10) @(posedge i_ref_clk);
		#1 chk16(16'(s_oe_n), 16'h0FFF);
		chk16(16'(o_cfg_valid), 16'h0000);
		@(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		#1 chk16(16'(o_cfg_valid), 16'h0001);
		chk16(16'(s_oe_n), 16'h0000);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Internal pulls only: every field takes its default
	task t_defaults;
		do_reset(rsl_straps_t'(12'h000), 1'b0);
		chk_cfg(o_cfg, exp_cfg(rsl_straps_t'(RSL_STRAP_DFLT), 1'b0));
		rd(RSL_REG_CTRL, 16'h3000);
		rd(RSL_REG_ADV, 16'h01E1);
	endtask
	// Every single-bit strap against its pull, then pad traffic after capture
	task t_inverted;
		rsl_straps_t s;
		s = rsl_straps_t'(12'h475);
		do_reset(s, 1'b1);
		chk_cfg(o_cfg, exp_cfg(s, 1'b0));
		rd(RSL_REG_CTRL, 16'h0500);
		rd(RSL_REG_ADV, 16'h0061);
		@(posedge i_ref_clk);
		func <= rsl_straps_t'(12'hA5C);
		board <= rsl_straps_t'(12'hB8A);
		@(posedge i_ref_clk);
		#1 chk16(16'(s_out), 16'h0A5C);
		repeat (4) @(posedge i_ref_clk);
		func <= rsl_straps_t'(12'h000);
		#1 chk_cfg(o_cfg, exp_cfg(s, 1'b0));
	endtask
	// Every mode code and every address value
	task t_codes;
		rsl_straps_t s;
		for (int i = 0; i < 8; i++) begin
			s = rsl_straps_t'(RSL_STRAP_DFLT);
			s.iface_mode_strap = 3'(i);
			s.mgmt_addr_strap = 3'(7 - i);
			do_reset(s, 1'b1);
			chk_cfg(o_cfg, exp_cfg(s, 1'b0));
		end
	endtask
	// Software broadcast-off, control overwrite, then re-sample
	task t_software;
		rsl_straps_t s;
		rsl_cfg_t e;
		s = rsl_straps_t'(12'hB80);
		do_reset(s, 1'b1);
		chk_cfg(o_cfg, exp_cfg(s, 1'b0));
		rd(RSL_REG_MISC, 16'h0000);
		wr(RSL_REG_MISC, 16'h0200);
		chk_cfg(o_cfg, exp_cfg(s, 1'b1));
		rd(RSL_REG_MISC, 16'h0200);
		rd(RSL_REG_STRAP, {4'h0, 12'(s)});
		wr(RSL_REG_CTRL, 16'h0000);
		e = exp_cfg(s, 1'b1);
		e.speed_100 = 1'b0;
		e.autoneg_en = 1'b0;
		chk_cfg(o_cfg, e);
		wr(5'h1F, 16'hFFFF);
		rd(5'h1F, 16'h0000);
		rd(RSL_REG_CTRL, 16'h0000);
		do_reset(s, 1'b1);
		rd(RSL_REG_MISC, 16'h0000);
		rd(RSL_REG_CTRL, exp_ctrl(s));
		chk_cfg(o_cfg, exp_cfg(s, 1'b0));
	endtask

	// ****************************************************************
	// Run control
	// ****************************************************************
	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence; inputs start in reset with no board straps
	initial begin
		i_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 5'h00;
		i_wdata = 16'h0000;
		func = rsl_straps_t'(12'h000);
		board = rsl_straps_t'(12'h000);
		fitted = 1'b0;
		t_defaults();
		t_inverted();
		t_codes();
		t_software();
		stop_test();
	end

	// Whole run needs under two hundred cycles; far beyond that is a hang
	initial begin
		#(50 * 20000);
		n_fail++;
		stop_test();
	end
endmodule
